// *** rtl/csc_card_select.v ***
`timescale 1ns/1ps
`include "csc_map.vh"
module csc_card_select #(
    parameter WDOG_CYCLES = `CSC_WDOG_MS * `CSC_CLK_KHZ
) (
    // clock and reset
    input  wire                   i_clk,
    input  wire                   i_rst,
    // microaddress from the sequencer, same clock domain
    input  wire [13:0]            i_uaddr,
    input  wire                   i_uaddr_valid,
    // frontplane priority chain
    input  wire                   i_prio_in,
    output wire                   o_prio_out,
    // backplane i/o for the writable card
    input  wire                   i_io_wr,
    input  wire                   i_io_rd,
    input  wire [5:0]             i_io_code,
    input  wire [15:0]            i_io_acc,
    input  wire                   i_io_mem_wr,
    input  wire                   i_io_mem_rd,
    input  wire [11:0]            i_io_mem_addr,
    input  wire [31:0]            i_io_mem_wdata,
    output reg  [31:0]            o_io_mem_rdata,
    output reg                    o_io_mem_ack,
    output reg                    o_io_mem_refused,
    output wire                   o_card_on,
    // writable card block switches, one 4-bit block per module
    input  wire [15:0]            i_wr_blk_sw,
    // read-only card module switches
    input  wire [31:0]            i_ro_blk_sw,
    input  wire [7:0]             i_ro_mod_dis,
    input  wire                   i_ro_wr_first,
    // read-only module contents, looked up outside
    output wire [13:0]            o_ro_lookup_addr,
    input  wire [31:0]            i_ro_lookup_data,
    // built-in store data
    input  wire [31:0]            i_base_data,
    // control-store data bus
    output reg  [31:0]            o_cs_data,
    output reg                    o_cs_data_oe,
    output reg  [1:0]             o_cs_source,
    // watchdog
    input  wire                   i_irq_pend,
    input  wire                   i_irq_serviced,
    output wire                   o_wdog_abort
);
    // ------------------------------------------------------------
    // switch synchronisers
    // ------------------------------------------------------------
    // switches are pins; two flops keep a change in mid-cycle from
    // splitting one decode across old and new settings
    reg  [15:0] wr_blk_sw_s1;
    reg  [15:0] wr_blk_sw;
    reg  [31:0] ro_blk_sw_s1;
    reg  [31:0] ro_blk_sw;
    reg  [7:0]  ro_mod_dis_s1;
    reg  [7:0]  ro_mod_dis;
    reg         ro_wr_first_s1;
    reg         ro_wr_first;

    // no reset: the flops fill while reset is held, so the first
    // microaddress after release already sees the real settings
    always @(posedge i_clk) begin
        wr_blk_sw_s1   <= i_wr_blk_sw;
        wr_blk_sw      <= wr_blk_sw_s1;
        ro_blk_sw_s1   <= i_ro_blk_sw;
        ro_blk_sw      <= ro_blk_sw_s1;
        ro_mod_dis_s1  <= i_ro_mod_dis;
        ro_mod_dis     <= ro_mod_dis_s1;
        ro_wr_first_s1 <= i_ro_wr_first;
        ro_wr_first    <= ro_wr_first_s1;
    end

    // ------------------------------------------------------------
    // writable card state and memory
    // ------------------------------------------------------------
    reg  [31:0] wr_mem [0:4095];
    reg         card_on;
    assign o_card_on = card_on;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            card_on <= 1'b0;
        end else if (i_io_wr && i_io_code == `CSC_IO_CODE) begin
            card_on <= i_io_acc[`CSC_SIGN_BIT];
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire [`CSC_BLK_W-1:0]   blk = i_uaddr[`CSC_BLK_MSB:`CSC_BLK_LSB];
    wire [`CSC_WR_MODS-1:0] wr_mod_hit;
    wire [`CSC_MOD_CNT-1:0] ro_mod_hit;

    genvar g;
    generate
        for (g = 0; g < `CSC_WR_MODS; g = g + 1) begin : g_wr_dec
            assign wr_mod_hit[g] = (wr_blk_sw[g*`CSC_BLK_W +: `CSC_BLK_W] == blk);
        end
        for (g = 0; g < `CSC_MOD_CNT; g = g + 1) begin : g_ro_dec
            assign ro_mod_hit[g] = !ro_mod_dis[g] && (ro_blk_sw[g*`CSC_BLK_W +: `CSC_BLK_W] == blk);
        end
    endgenerate

    reg        wr_hit;
    reg [1:0]  wr_mod;
    reg        ro_hit;
    always @* begin
        wr_hit = card_on && i_uaddr_valid && (|wr_mod_hit);
        ro_hit = i_uaddr_valid && (|ro_mod_hit);
        // two modules on one block is a switch error; the highest one wins
        if (wr_mod_hit[3]) begin
            wr_mod = 2'h3;
        end else if (wr_mod_hit[2]) begin
            wr_mod = 2'h2;
        end else if (wr_mod_hit[1]) begin
            wr_mod = 2'h1;
        end else begin
            wr_mod = 2'h0;
        end
    end
    assign o_ro_lookup_addr = i_uaddr;

    // priority: ro_wr_first puts the writable card below, else above
    wire wr_win  = i_prio_in && wr_hit && !(ro_wr_first && ro_hit);
    wire ro_win  = i_prio_in && ro_hit && !wr_win;
    assign o_prio_out = i_prio_in && !wr_hit && !ro_hit;

    // ------------------------------------------------------------
    // backplane access
    // ------------------------------------------------------------
    wire io_access = i_io_mem_wr || i_io_mem_rd;

    // no reset on the array: microcode survives a processor reset
    always @(posedge i_clk) begin
        if (i_io_mem_wr && !card_on) begin
            wr_mem[i_io_mem_addr] <= i_io_mem_wdata;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_io_mem_rdata   <= 32'h0;
            o_io_mem_ack     <= 1'b0;
            o_io_mem_refused <= 1'b0;
        end else begin
            o_io_mem_ack     <= io_access && !card_on;
            o_io_mem_refused <= io_access && card_on;
            if (i_io_mem_rd && !card_on) begin
                o_io_mem_rdata <= wr_mem[i_io_mem_addr];
            end
        end
    end

    // ------------------------------------------------------------
    // control-store data bus
    // ------------------------------------------------------------
    wire [`CSC_WR_AW-1:0] wr_index = {wr_mod, i_uaddr[`CSC_OFS_W-1:0]};
    reg  [1:0]            next_cs_source;

    // the array is read in the clocked process, where a write that lands
    // while the address stands still is seen on the next fetch
    always @* begin
        if (wr_win) begin
            next_cs_source = `CSC_SRC_WR;
        end else if (ro_win) begin
            next_cs_source = `CSC_SRC_RO;
        end else begin
            next_cs_source = `CSC_SRC_BASE;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cs_data    <= 32'h0;
            o_cs_data_oe <= 1'b0;
            o_cs_source  <= `CSC_SRC_BASE;
        end else begin
            o_cs_data_oe <= wr_win || ro_win || i_prio_in;
            o_cs_source  <= next_cs_source;
            if (wr_win) begin
                o_cs_data <= wr_mem[wr_index];
            end else if (ro_win) begin
                o_cs_data <= i_ro_lookup_data;
            end else begin
                o_cs_data <= i_base_data;
            end
        end
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    csc_wdog #(
        .LIMIT(WDOG_CYCLES)
    ) u_wdog (
        .i_clk         (i_clk),
        .i_rst         (i_rst),
        .i_irq_pend    (i_irq_pend),
        .i_irq_serviced(i_irq_serviced),
        .o_abort       (o_wdog_abort)
    );
endmodule

// *** rtl/csc_map.vh ***
`ifndef CSC_MAP_VH
`define CSC_MAP_VH
// address and word shape
`define CSC_ADDR_W      14
`define CSC_DATA_W      32
`define CSC_BLK_W       4
`define CSC_BLK_LSB     10
`define CSC_BLK_MSB     13
`define CSC_OFS_W       10
`define CSC_MOD_CNT     8
// writable card: 4k words, four 1k modules
`define CSC_WR_AW       12
`define CSC_WR_MODS     4
`define CSC_WR_MOD_W    2
// i/o command code for enable/disable
`define CSC_IO_CODE     6'h20
`define CSC_SIGN_BIT    15
// control-store source codes
`define CSC_SRC_BASE    2'h0
`define CSC_SRC_WR      2'h1
`define CSC_SRC_RO      2'h2
// watchdog: 10 ms at 100 MHz
`define CSC_WDOG_MS     10
`define CSC_CLK_KHZ     100000
`endif

// *** rtl/csc_wdog.v ***
`timescale 1ns/1ps
`include "csc_map.vh"
module csc_wdog #(
    parameter LIMIT = `CSC_WDOG_MS * `CSC_CLK_KHZ
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // interrupt status
    input  wire        i_irq_pend,
    input  wire        i_irq_serviced,
    // abort pulse
    output reg         o_abort
);
    reg [31:0] count;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count   <= 32'h0;
            o_abort <= 1'b0;
        end else begin
            o_abort <= 1'b0;
            if (!i_irq_pend || i_irq_serviced) begin
                count <= 32'h0;
            end else if (count == LIMIT - 1) begin
                count   <= 32'h0;
                o_abort <= 1'b1;
            end else begin
                count <= count + 32'h1;
            end
        end
    end
endmodule

// *** testbench/control_store_card_select_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t mismatch got %h exp %h", $time, a, b); end end
module control_store_card_select_tb;
    logic        i_clk = 0, i_rst = 1, i_prio_in = 1, i_io_wr = 0, i_io_rd = 0, i_io_mem_wr = 0, i_io_mem_rd = 0;
    logic        i_ro_wr_first = 0, i_irq_pend = 0, i_irq_serviced = 0, i_uaddr_valid;
    logic        o_prio_out, o_io_mem_ack, o_io_mem_refused, o_card_on, o_cs_data_oe, o_wdog_abort;
    logic [5:0]  i_io_code = 0;
    logic [7:0]  i_ro_mod_dis = 8'hfe;
    logic [11:0] i_io_mem_addr = 0;
    logic [13:0] i_uaddr, o_ro_lookup_addr;
    logic [15:0] i_io_acc = 0, i_wr_blk_sw = 16'h7653;
    logic [31:0] i_ro_blk_sw = 32'h3, i_io_mem_wdata = 0, o_io_mem_rdata, o_cs_data, i_base_data = 32'hbade_0000;
    logic [1:0]  o_cs_source;
    wire  [31:0] i_ro_lookup_data = {18'h0, o_ro_lookup_addr} ^ 32'ha5a5_0000;
    int          fails = 0, checks = 0;
    always #5 i_clk = ~i_clk;
    csc_seq_model seq (.i_clk, .o_uaddr(i_uaddr), .o_valid(i_uaddr_valid));
    csc_card_select #(.WDOG_CYCLES(50)) uut (.i_clk, .i_rst, .i_uaddr, .i_uaddr_valid, .i_prio_in, .o_prio_out,
        .i_io_wr, .i_io_rd, .i_io_code, .i_io_acc, .i_io_mem_wr, .i_io_mem_rd, .i_io_mem_addr, .i_io_mem_wdata,
        .o_io_mem_rdata, .o_io_mem_ack, .o_io_mem_refused, .o_card_on, .i_wr_blk_sw, .i_ro_blk_sw, .i_ro_mod_dis,
        .i_ro_wr_first, .o_ro_lookup_addr, .i_ro_lookup_data, .i_base_data, .o_cs_data, .o_cs_data_oe,
        .o_cs_source, .i_irq_pend, .i_irq_serviced, .o_wdog_abort);
    task automatic cmd(input logic [5:0] c, input logic [15:0] a, input logic on);
        @(posedge i_clk);
        i_io_wr <= 1;
        i_io_code <= c;
        i_io_acc <= a;
        @(posedge i_clk);
        i_io_wr <= 0;
        #1 `CHK(o_card_on, on)
    endtask
    task automatic mem(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic on);
        @(posedge i_clk);
        i_io_mem_wr <= wr;
        i_io_mem_rd <= !wr;
        i_io_mem_addr <= a;
        i_io_mem_wdata <= d;
        @(posedge i_clk);
        i_io_mem_wr <= 0;
        i_io_mem_rd <= 0;
        #1 `CHK({o_io_mem_ack, o_io_mem_refused}, {!on, on})
        if (!wr && !on) `CHK(o_io_mem_rdata, d)
    endtask
    task automatic run(input logic [13:0] a, input logic [1:0] s, input logic [31:0] d);
        fork
            seq.send(a);
            begin
                @(posedge i_clk);
                #1 `CHK(o_prio_out, i_prio_in && s == 2'd0)
            end
        join
        #1 `CHK({o_cs_data_oe, o_cs_source, o_cs_data}, {1'b1, s, d})
    endtask
    // ---
    // scenarios
    // ---
    task automatic t_switch;
        cmd(6'h21, 16'h8000, 0);
        cmd(6'h20, 16'h8000, 1);
        cmd(6'h20, 16'h7fff, 0);
    endtask
    task automatic t_load;
        mem(1, 12'h3ff, 32'hcafe_0001, 0);
        mem(0, 12'h3ff, 32'hcafe_0001, 0);
        mem(1, 12'hfff, 32'h1234_5678, 0);
        mem(0, 12'hfff, 32'h1234_5678, 0);
    endtask
    task automatic t_exec;
        cmd(6'h20, 16'h8000, 1);
        run(14'h0fff, 1, 32'hcafe_0001);
        run(14'h1fff, 1, 32'h1234_5678);
        mem(1, 12'h3ff, 32'h0, 1);
        run(14'h0fff, 1, 32'hcafe_0001);
        cmd(6'h20, 16'h0000, 0);
        run(14'h0fff, 2, 32'ha5a5_0fff);
        // switches reach the decode two cycles late through the synchroniser
        @(posedge i_clk) i_ro_wr_first <= 1;
        cmd(6'h20, 16'h8000, 1);
        repeat (2) @(posedge i_clk);
        run(14'h0fff, 2, 32'ha5a5_0fff);
        run(14'h1fff, 1, 32'h1234_5678);
        cmd(6'h20, 16'h0000, 0);
        @(posedge i_clk) i_ro_wr_first <= 0;
        @(posedge i_clk) i_ro_mod_dis <= 8'hff;
        repeat (2) @(posedge i_clk);
        run(14'h0fff, 0, 32'hbade_0000);
        @(posedge i_clk) i_prio_in <= 0;
        seq.send(14'h0fff);
        #1 `CHK(o_cs_data_oe, 1'b0)
        @(posedge i_clk) i_prio_in <= 1;
    endtask
    task automatic t_wdog;
        int n;
        n = 0;
        @(posedge i_clk) i_irq_pend <= 1;
        repeat (30) @(posedge i_clk);
        i_irq_serviced <= 1;
        @(posedge i_clk) i_irq_serviced <= 0;
        while (o_wdog_abort !== 1'b1 && n < 100) begin
            @(posedge i_clk) #1;
            n++;
        end
        `CHK(o_wdog_abort, 1'b1)
        `CHK(n, 50)
        i_irq_pend <= 0;
    endtask
    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #20000;
        fails++;
        summarize;
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 0;
        t_switch;
        t_load;
        t_exec;
        t_wdog;
        summarize;
    end
endmodule

// *** testbench/csc_monitor.sv ***
`timescale 1ns/1ps
// ---
// card select checks
// ---
module csc_monitor (
    input logic        i_clk, i_rst, i_uaddr_valid, i_prio_in, o_prio_out, i_io_wr, i_ro_wr_first,
    input logic        i_io_mem_rd, i_io_mem_wr, o_io_mem_ack, o_io_mem_refused, o_card_on,
    input logic        o_cs_data_oe, i_irq_pend, o_wdog_abort,
    input logic [13:0] i_uaddr,
    input logic [5:0]  i_io_code,
    input logic [15:0] i_io_acc, i_wr_blk_sw,
    input logic [1:0]  o_cs_source
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_cmd; i_io_wr && i_io_code == 6'h20; endsequence
    sequence s_mem; i_io_mem_rd || i_io_mem_wr; endsequence
    sequence s_hit; o_card_on && i_uaddr_valid && i_prio_in && !i_ro_wr_first && i_uaddr[13:10] == i_wr_blk_sw[3:0];
    endsequence
    chk_prio_block: assert property (!i_prio_in |-> !o_prio_out) else $error("chain leak");
    chk_oe_prio: assert property (i_uaddr_valid && i_prio_in |=> o_cs_data_oe) else $error("no drive");
    chk_oe_held: assert property (i_uaddr_valid && !i_prio_in |=> !o_cs_data_oe) else $error("drove");
    chk_on_off: assert property (s_cmd |=> o_card_on == $past(i_io_acc[15])) else $error("state");
    chk_mem_refuse: assert property (o_card_on ##0 s_mem |=> o_io_mem_refused && !o_io_mem_ack) else $error("ref");
    chk_mem_allow: assert property (!o_card_on ##0 s_mem |=> o_io_mem_ack && !o_io_mem_refused) else $error("ack");
    chk_off_quiet: assert property (!o_card_on && i_uaddr_valid |=> o_cs_source != 2'd1) else $error("off drove");
    chk_wr_wins: assert property (s_hit |-> !o_prio_out ##1 o_cs_source == 2'd1) else $error("lost");
    chk_wdog_idle: assert property ((!i_irq_pend)[*2] |-> !o_wdog_abort) else $error("abort");
endmodule
bind csc_card_select csc_monitor u_mon (
    .i_clk           (i_clk),
    .i_rst           (i_rst),
    .i_uaddr_valid   (i_uaddr_valid),
    .i_prio_in       (i_prio_in),
    .o_prio_out      (o_prio_out),
    .i_io_wr         (i_io_wr),
    .i_ro_wr_first   (i_ro_wr_first),
    .i_io_mem_rd     (i_io_mem_rd),
    .i_io_mem_wr     (i_io_mem_wr),
    .o_io_mem_ack    (o_io_mem_ack),
    .o_io_mem_refused(o_io_mem_refused),
    .o_card_on       (o_card_on),
    .o_cs_data_oe    (o_cs_data_oe),
    .i_irq_pend      (i_irq_pend),
    .o_wdog_abort    (o_wdog_abort),
    .i_uaddr         (i_uaddr),
    .i_io_code       (i_io_code),
    .i_io_acc        (i_io_acc),
    .i_wr_blk_sw     (i_wr_blk_sw),
    .o_cs_source     (o_cs_source)
);

// *** testbench/csc_seq_model.sv ***
`timescale 1ns/1ps
module csc_seq_model (
    input  logic        i_clk,
    output logic [13:0] o_uaddr,
    output logic        o_valid
);
    initial begin
        o_uaddr = 14'h0000;
        o_valid = 1'b0;
    end
    // released bus shows the inverse so a stale address cannot pass
    task automatic send(input logic [13:0] a);
        @(posedge i_clk);
        o_uaddr <= a;
        o_valid <= 1'b1;
        @(posedge i_clk);
        o_uaddr <= ~a;
        o_valid <= 1'b0;
    endtask
endmodule
